// >>> shared/tec_pkg.sv
// Constants, register map and field layout for the 8-bit timer/event counter.
// Function
// (R1) Counter is an 8-bit software-programmable up-counter.
// (R2) Internal count clock is slow oscillator divided by one to 128.
// (R3) Reading the count register returns the running counter, not the preload.
// (R4) Event mode counts transitions on the count input pin.
// (R5) Timer mode counts the prescaled internal clock.
// (R6) Capture mode counts internal clock during a high or low input pulse.
// (R7) Event and timer modes count on from the current value past all-ones.
// (R8) Every overflow reloads from preload and sets the overflow request flag.
// (R9) Capture starts on the selected edge, stops and clears run on return.
// (R10) After one capture the count is held until run is set again.
// (R11) Capture starts only on a transition, never on a level already present.
// (R12) Overflow during capture reloads and flags as in other modes.
// (R13) Count only while run is set; hardware clears run only in capture.
// (R14) Counter overflow is a wake-up event.
// (R15) Write while stopped loads both preload and counter.
// (R16) Write while running loads only preload; counter picks it up at overflow.
// (R17) Counting clock is blocked during a count register read.
// (R18) Software should write a start value before first enabling the counter.
// (R19) Software should enable then disable the counter once before first use.
// (R20) Mode codes: 00 unused, 01 event, 10 timer, 11 capture.
// (R21) Event mode edge select 0 counts rising, 1 counts falling edges.
// (R22) Prescale code 000 divides by one up to 111 dividing by 128.
// (R23) Event counting continues in low-power modes and its overflow wakes.
// (R24) Count input is synchronised and edges taken from synchronised samples.
package tec_pkg;
    localparam logic [11:0] count_value_addr = 12'h000;
    localparam logic [11:0] counter_control_addr = 12'h004;
    localparam logic [11:0] flag_addr = 12'h008;
    localparam int mode_hi_bit = 7;
    localparam int mode_lo_bit = 6;
    localparam int run_bit = 4;
    localparam int edge_bit = 3;
    localparam int psc_hi_bit = 2;
    localparam logic [7:0] control_reset = 8'h08;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [1:0] mode_unused = 2'h0;
    localparam logic [1:0] mode_event = 2'h1;
    localparam logic [1:0] mode_timer = 2'h2;
    localparam logic [1:0] mode_capture = 2'h3;
    localparam logic [7:0] count_all_ones = 8'hff;
    localparam int psc_width = 7;
    localparam logic [7:0] control_write_mask = 8'hdf;
    typedef enum logic [2:0] {
        cap_idle = 3'b001,
        cap_arm = 3'b010,
        cap_count = 3'b100
    } cap_state_e;
endpackage

// >>> hw/timer_event_counter_8bit.sv
// Eight-bit timer/event counter with preload, prescaler, capture mode and APB slave.
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_8bit (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic slow_osc_tick,
    input wire logic count_input_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic overflow_request_flag,
    output logic wake_pulse
);
    import tec_pkg::*;

    // Registers and next values.
    logic [7:0] count_ff, nxt_count;
    logic [7:0] preload_ff, nxt_preload;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic flag_ff, nxt_flag;
    logic wake_ff, nxt_wake;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;
    logic err_ff, nxt_err;
    logic [psc_width-1:0] psc_ff, nxt_psc;
    logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic tick_ff, nxt_tick;
    cap_state_e cap_ff, nxt_cap;

    logic [1:0] mode;
    logic run;
    logic edge_sel;
    logic [2:0] psc_code;
    logic rise, fall;
    logic setup_ph, wr_acc, rd_acc;
    logic count_en;
    logic ovf;
    logic int_tick;
    logic cap_start, cap_stop;

    assign mode = ctrl_ff[mode_hi_bit:mode_lo_bit];
    assign run = ctrl_ff[run_bit];
    assign edge_sel = ctrl_ff[edge_bit];
    assign psc_code = ctrl_ff[psc_hi_bit:0];

    // The first stage feeds only the second; edges come from stages two and three.
    // The stages reset low, so a pin that idles high shows one false rise after reset.
    logic nxt_pin_s1, nxt_pin_s2, nxt_pin_s3;
    always_comb begin
        nxt_pin_s1 = count_input_pin; // see (R24)
        nxt_pin_s2 = pin_s1_ff;
        nxt_pin_s3 = pin_s2_ff;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_s3_ff <= 1'b0;
        end else begin
            pin_s1_ff <= nxt_pin_s1;
            pin_s2_ff <= nxt_pin_s2;
            pin_s3_ff <= nxt_pin_s3;
        end
    end
    assign rise = pin_s2_ff & ~pin_s3_ff; // see (R24)
    assign fall = ~pin_s2_ff & pin_s3_ff; // see (R24)

    // Prescaler: divide-by-2^n pulse built on oscillator ticks.
    logic [psc_width-1:0] psc_mask;
    always_comb begin
        psc_mask = (7'h1 << psc_code) - 7'h1;
        nxt_psc = psc_ff;
        nxt_tick = 1'b0;
        if (slow_osc_tick) begin
            nxt_psc = psc_ff + 7'h1;
            // A tick leaves when the low code bits are all ones, so code zero passes every tick.
            nxt_tick = (psc_ff & psc_mask) == psc_mask; // see (R2) (R22)
        end
    end
    assign int_tick = tick_ff;

    // APB decode: accesses complete in the first access cycle, with no wait state after setup.
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & ready_ff;
    assign rd_acc = psel & penable & ~pwrite;

    // Capture sequencing.
    always_comb begin
        nxt_cap = cap_ff;
        cap_start = 1'b0;
        cap_stop = 1'b0;
        unique case (cap_ff)
            cap_idle: begin
                if (mode == mode_capture && run) begin
                    nxt_cap = cap_arm; // see (R11)
                end
            end
            cap_arm: begin
                if (mode != mode_capture || !run) begin
                    nxt_cap = cap_idle;
                end else if ((edge_sel && rise) || (!edge_sel && fall)) begin
                    nxt_cap = cap_count; // see (R9)
                    cap_start = 1'b1;
                end
            end
            cap_count: begin
                if (mode != mode_capture || !run) begin
                    nxt_cap = cap_idle;
                end else if ((edge_sel && fall) || (!edge_sel && rise)) begin
                    nxt_cap = cap_idle; // see (R9) (R10)
                    cap_stop = 1'b1;
                end
            end
        endcase
    end

    // Counting enable per mode; a read in progress holds the count still.
    always_comb begin
        count_en = 1'b0;
        if (run && !rd_acc) begin // see (R13) (R17)
            unique case (mode)
                mode_event: count_en = edge_sel ? fall : rise; // see (R4) (R21) (R23)
                mode_timer: count_en = int_tick; // see (R5)
                mode_capture: count_en = int_tick && cap_ff == cap_count && !cap_stop; // see (R6)
                mode_unused: count_en = 1'b0; // see (R20)
            endcase
        end
    end
    assign ovf = count_en && count_ff == count_all_ones; // see (R7)

    // Counter, preload, control and flag next values.
    always_comb begin
        nxt_count = count_ff;
        nxt_preload = preload_ff;
        nxt_ctrl = ctrl_ff;
        nxt_flag = flag_ff;
        nxt_wake = 1'b0;
        if (count_en) begin
            nxt_count = ovf ? preload_ff : count_ff + 8'h01; // see (R1) (R8) (R12)
        end
        if (cap_stop) begin
            nxt_ctrl[run_bit] = 1'b0; // see (R9) (R13)
        end
        if (wr_acc && paddr == count_value_addr) begin
            nxt_preload = pwdata[7:0]; // see (R16)
            if (!run) begin
                nxt_count = pwdata[7:0]; // see (R15)
            end
        end
        if (wr_acc && paddr == counter_control_addr) begin
            nxt_ctrl = pwdata[7:0] & control_write_mask;
        end
        // Software clears the flag by writing one; an overflow in the same cycle wins.
        if (wr_acc && paddr == flag_addr && pwdata[0]) begin
            nxt_flag = 1'b0;
        end
        if (ovf) begin
            nxt_flag = 1'b1; // see (R8) (R12)
            nxt_wake = 1'b1; // see (R14) (R23)
        end
    end

    // APB answer path.
    always_comb begin
        nxt_ready = setup_ph;
        nxt_err = 1'b0;
        nxt_rdata = 32'h0;
        if (setup_ph) begin
            unique case (paddr)
                count_value_addr: nxt_rdata = {24'h0, count_ff}; // see (R3)
                counter_control_addr: nxt_rdata = {24'h0, ctrl_ff};
                flag_addr: nxt_rdata = {31'h0, flag_ff};
                default: nxt_err = 1'b1;
            endcase
        end else if (rd_acc && ready_ff) begin
            nxt_rdata = rdata_ff;
        end
    end

    // Counter group registers.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_ff <= count_reset;
            preload_ff <= count_reset;
            ctrl_ff <= control_reset;
            flag_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            preload_ff <= nxt_preload;
            ctrl_ff <= nxt_ctrl;
            flag_ff <= nxt_flag;
            wake_ff <= nxt_wake;
        end
    end

    // Bus answer registers; every bus output leaves straight from one of these.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
        end
    end

    // Prescaler registers.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            psc_ff <= 7'h0;
            tick_ff <= 1'b0;
        end else begin
            psc_ff <= nxt_psc;
            tick_ff <= nxt_tick;
        end
    end

    // Capture sequencer register.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cap_ff <= cap_idle;
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign overflow_request_flag = flag_ff;
    assign wake_pulse = wake_ff;

    overflow_reload_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R8)
        ovf |=> count_ff == $past(preload_ff) && flag_ff)
        else $error("Overflow did not reload and flag.");
    overflow_wake_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R14)
        ovf |=> wake_pulse)
        else $error("Overflow did not wake.");
    read_block_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R17)
        (rd_acc && !(wr_acc && paddr == count_value_addr)) |=> $stable(count_ff))
        else $error("Counter moved during read.");
    stopped_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R13)
        (!run && !wr_acc) |=> $stable(count_ff))
        else $error("Counter moved while stopped.");
    run_kept_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R13)
        (run && mode != mode_capture && !wr_acc) |=> run)
        else $error("Run bit cleared by hardware outside capture.");
    stopped_load_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R15)
        (wr_acc && paddr == count_value_addr && !run) |=> count_ff == $past(pwdata[7:0]))
        else $error("Stopped write did not load counter.");
    running_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R16)
        (wr_acc && paddr == count_value_addr && run && !count_en)
        |=> preload_ff == $past(pwdata[7:0]) && $stable(count_ff))
        else $error("Running write disturbed counter.");
    event_edge_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R21)
        (mode == mode_event && run && !rd_acc && !wr_acc && !edge_sel && rise
         && count_ff != count_all_ones) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("Event edge not counted.");
    capture_stop_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R9)
        cap_stop && !wr_acc |=> !run)
        else $error("Capture end did not clear run.");
    capture_arm_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R11)
        (cap_ff == cap_arm && mode == mode_capture) |-> !count_en)
        else $error("Capture counted before start edge.");
    capture_idle_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R10)
        (cap_ff == cap_idle && mode == mode_capture) |-> !count_en)
        else $error("Capture counted after completion.");
    capture_start_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R9)
        (cap_ff == cap_arm && mode == mode_capture && run
         && ((edge_sel && rise) || (!edge_sel && fall))) |=> cap_ff == cap_count)
        else $error("Capture did not start on active edge.");
    capture_count_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R6)
        (cap_ff == cap_count && mode == mode_capture && run && int_tick && !cap_stop
         && !rd_acc && count_ff != count_all_ones) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("Capture did not count internal tick.");
    capture_ovf_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R12)
        (ovf && mode == mode_capture) |=> flag_ff)
        else $error("Capture overflow not flagged.");
    timer_tick_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R5)
        (mode == mode_timer && run && !rd_acc && int_tick
         && count_ff != count_all_ones) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("Timer tick not counted.");
    event_fall_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R21)
        (mode == mode_event && run && !rd_acc && edge_sel && fall
         && count_ff != count_all_ones) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("Falling event edge not counted.");
    unused_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R20)
        (mode == mode_unused && !wr_acc) |=> $stable(count_ff))
        else $error("Counter moved in unused mode.");
    wake_only_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R14)
        !ovf |=> !wake_pulse)
        else $error("Wake without overflow.");
    tick_source_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R2)
        int_tick |-> $past(slow_osc_tick))
        else $error("Internal tick without oscillator tick.");
    read_value_a: assert property (@(posedge mclk) disable iff (sys_rst) // see (R3)
        (setup_ph && !pwrite && paddr == count_value_addr) |=> prdata[7:0] == $past(count_ff))
        else $error("Count read did not return running counter.");
    ready_once_a: assert property (@(posedge mclk) disable iff (sys_rst)
        setup_ph |=> pready)
        else $error("Bus access not answered after setup.");
    ready_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("Bus ready stood longer than one cycle.");
endmodule // timer_event_counter_8bit
`default_nettype wire

// >>> bench/pulse_source.sv
// Partner model: an external event or pulse source driving the count input pin.
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    input wire logic mclk,
    input wire logic go,
    input wire logic idle,
    input wire logic [7:0] n,
    input wire logic [7:0] hi_len,
    input wire logic [7:0] lo_len,
    output var logic count_input_pin,
    output var logic busy
);
    // The pin rests at the idle level, so a level change alone can be tried against capture.
    initial begin
        count_input_pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (!go) begin
                count_input_pin <= idle;
            end else begin
                busy <= 1'b1;
                repeat (n) begin
                    count_input_pin <= ~idle;
                    repeat (hi_len) @(posedge mclk);
                    count_input_pin <= idle;
                    repeat (lo_len) @(posedge mclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // pulse_source
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the 8-bit timer/event counter.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tec_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic err;} row_s;
    logic mclk = 1'b0, sys_rst = 1'b1, slow_osc_tick = 1'b0, count_input_pin, busy;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, idle = 1'b0, e, pready;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, c;
    logic pslverr, overflow_request_flag, wake_pulse;
    logic [7:0] n = 8'h00, hi_len = 8'h03, lo_len = 8'h03;
    logic [1:0] tdiv = 2'h0;
    int miscompares = 0, total_checks = 0, wakes = 0;
    row_s rows[3] = '{'{12'h000, 32'h5a, 32'h5a, 1'b0}, '{12'h004, 32'h2f, 32'h0f, 1'b0},
                      '{12'h00c, 32'h77, 32'h0, 1'b1}};
    timer_event_counter_8bit dut (.mclk(mclk), .sys_rst(sys_rst), .slow_osc_tick(slow_osc_tick),
        .count_input_pin(count_input_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overflow_request_flag(overflow_request_flag), .wake_pulse(wake_pulse));
    pulse_source src (.mclk(mclk), .go(go), .idle(idle), .n(n), .hi_len(hi_len),
        .lo_len(lo_len), .count_input_pin(count_input_pin), .busy(busy));
    always #5 mclk = ~mclk;
    // One slow oscillator tick every four system cycles.
    always @(posedge mclk) begin
        tdiv <= tdiv + 2'h1;
        slow_osc_tick <= (tdiv == 2'h3);
        if (wake_pulse === 1'b1) wakes++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) miscompares++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released edge between transfers keeps each strobe assigned once per time step.
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
        apb(a, 1'b0, 32'h0);
        chk(r, x, m);
    endtask
    task automatic pulses(input logic [7:0] cnt, input logic [7:0] h, input logic [7:0] l);
        int k;
        n <= cnt;
        hi_len <= h;
        lo_len <= l;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (busy === 1'b1 && k < 2000);
        // Synchroniser and edge detect need two cycles, the count one more.
        repeat (6) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(counter_control_addr, {24'h0, control_reset}, "ctl reset");
        rd(count_value_addr, 32'h0, "cnt reset");
        apb(counter_control_addr, 1'b1, 32'h50);
        apb(counter_control_addr, 1'b1, 32'h00);
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].err}, "err");
            rd(rows[i].a, rows[i].x, "row");
        end
        $display("registers done");
        apb(count_value_addr, 1'b1, 32'hfd);
        apb(counter_control_addr, 1'b1, 32'h50);
        apb(count_value_addr, 1'b1, 32'h20);
        rd(count_value_addr, 32'hfd, "no disturb");
        pulses(8'h03, 8'h03, 8'h03);
        rd(count_value_addr, 32'h20, "reload");
        rd(flag_addr, 32'h1, "flag");
        chk({31'h0, overflow_request_flag}, 32'h1, "flag pin");
        chk(wakes, 1, "wake");
        rd(counter_control_addr, 32'h50, "run kept");
        apb(flag_addr, 1'b1, 32'h1);
        rd(flag_addr, 32'h0, "flag clr");
        chk({31'h0, overflow_request_flag}, 32'h0, "flag pin clr");
        apb(counter_control_addr, 1'b1, 32'h58);
        pulses(8'h02, 8'h03, 8'h03);
        rd(count_value_addr, 32'h22, "falling");
        apb(counter_control_addr, 1'b1, 32'h10);
        pulses(8'h02, 8'h03, 8'h03);
        rd(count_value_addr, 32'h22, "mode unused");
        $display("event done");
        apb(counter_control_addr, 1'b1, 32'h00);
        apb(count_value_addr, 1'b1, 32'h00);
        apb(counter_control_addr, 1'b1, 32'h93);
        repeat (160) @(posedge mclk);
        apb(count_value_addr, 1'b0, 32'h0);
        // The tick phase is free against the divider, so one count either way is allowed.
        chk(r >= 32'h4 && r <= 32'h6, 1, "timer rate");
        apb(counter_control_addr, 1'b1, 32'h83);
        apb(count_value_addr, 1'b0, 32'h0);
        c = r;
        repeat (64) @(posedge mclk);
        rd(count_value_addr, c, "stopped");
        $display("timer done");
        apb(count_value_addr, 1'b1, 32'h00);
        idle <= 1'b1;
        repeat (10) @(posedge mclk);
        apb(counter_control_addr, 1'b1, 32'hd8);
        repeat (20) @(posedge mclk);
        rd(count_value_addr, 32'h0, "level only");
        idle <= 1'b0;
        repeat (10) @(posedge mclk);
        rd(count_value_addr, 32'h0, "wrong edge");
        pulses(8'h01, 8'h28, 8'h0a);
        apb(count_value_addr, 1'b0, 32'h0);
        c = r;
        chk(r >= 32'h9 && r <= 32'hb, 1, "width");
        rd(counter_control_addr, 32'hc8, "run cleared");
        pulses(8'h01, 8'h28, 8'h0a);
        rd(count_value_addr, c, "held");
        $display("capture done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(counter_control_addr, {24'h0, control_reset}, "ctl rerun");
        rd(count_value_addr, 32'h0, "cnt rerun");
        chk({31'h0, overflow_request_flag}, 32'h0, "flag rerun");
        $display("reset done");
        conclude();
    end
endmodule // tb
`default_nettype wire
